/* File: epc_ctrl.sv */
// Purpose: Program/erase control, protection and timebase of an on-chip byte-erasable array.
// Assumes: Single 25 MHz clock, synchronous active-high reset, stop and wait as inputs.
// Notes: The array cells themselves sit outside; this block drives their strobes.
// Operation
// - Power-down bit switches array off; reads undefined; reset clears it.
// - Protect and two select bits choose program, byte, block, bulk or nothing.
// - Latch bit captures array writes; cannot clear while high voltage set.
// - Auto bit lets the timer clear high voltage at cycle end.
// - High voltage applied only with latch set and valid write captured.
// - Clearing latch and high voltage together clears only high voltage.
// - Array config loads from shadow byte at reset; protect fields read-only.
// - Spare control bit 7 and config bits 7:5 store writes and do nothing; control bit 6 is not stored.
// - Security is active low and once enabled stays enabled.
// - Four protect bits each guard one 128-byte block.
// - Secured array allows byte program/erase only; 0x06F0-0x06FF fully locked.
// - Config shadow byte is programmed and erased like array bytes.
// - Reference divided by 11-bit value gives the 35 us timer tick.
// - Divider registers load from their shadow bytes at reset.
// - Divider always readable; writable only with latch clear and lock off.
// - Divider lock freezes divider registers and guards their shadow bytes.
// - Shadow lock bit programmed zero makes divider lock permanent.
// - Wait mode leaves a running cycle untouched.
// - Stop during cycle removes voltage; cycle restarts after stop, access blocked.
// - Stop with latch and voltage clear aborts at once.
// - High voltage cannot be set without latch and a valid captured address.
// - Later valid writes replace capture; reads return latched data, capture address.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps

module epc_ctrl #(
  parameter int ADDR_W = 16,
  parameter int DIV_W = 11
) (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Processor access to the array window.
  input wire epc_pkg::epc_bus_t cpu_bus,
  output logic [7:0] array_rdata,
  output logic array_busy,
  // Array cell side.
  input wire logic [7:0] cell_rdata,
  output logic array_power_down,
  output logic charge_pump_on,
  output epc_pkg::epc_cell_t cell_op,
  // Reference clock tick enable and low-power modes.
  input wire logic ref_tick,
  input wire logic stop_mode,
  input wire logic wait_mode
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] control_r;
  logic [7:0] array_config_r;
  logic [7:0] div_high_r;
  logic [7:0] div_low_r;
  // Shadow bytes leave the factory with an open array and the nominal divider.
  logic [7:0] nv_config_r = epc_pkg::NV_CONFIG_FACTORY;
  logic [7:0] nv_div_high_r = {1'b1, 4'h0, epc_pkg::DIV_RESET[10:8]};
  logic [7:0] nv_div_low_r = epc_pkg::DIV_RESET[7:0];
  logic [ADDR_W-1:0] cap_addr_r;
  logic [7:0] cap_data_r;
  logic cap_valid_r;
  logic [DIV_W-1:0] pre_cnt_r;
  logic tick_r;
  logic [11:0] tick_cnt_r;
  logic done_r;
  logic loaded_r;
  epc_pkg::epc_state_t state_r;

  logic hv_en;
  logic latch_en;
  logic auto_en;
  epc_pkg::epc_mode_t mode;
  logic secure;
  logic div_lock;
  logic wr_ctl;
  logic in_array;
  logic [1:0] blk;
  logic blocked;
  logic allowed;
  logic [11:0] limit;
  logic nv_target;
  logic window;
  logic erase_op;
  logic job_end_r;
  logic ran_out_r;

  assign hv_en = control_r[epc_pkg::CTL_HV_BIT];
  assign latch_en = control_r[epc_pkg::CTL_LATCH_BIT];
  assign auto_en = control_r[epc_pkg::CTL_AUTO_BIT];
  assign mode = epc_pkg::epc_mode_t'({control_r[epc_pkg::CTL_RAS_HI_BIT],
                                      control_r[epc_pkg::CTL_RAS_LO_BIT]});
  assign secure = ~array_config_r[4];
  assign div_lock = ~div_high_r[epc_pkg::DIV_SEC_BIT];
  assign wr_ctl = reg_wr && (reg_addr == epc_pkg::OFF_CONTROL);

  // Address decode for the array window and its 128-byte blocks.
  assign in_array = (cpu_bus.addr >= epc_pkg::ARRAY_BASE) && (cpu_bus.addr <= epc_pkg::ARRAY_LAST);
  assign blk = cpu_bus.addr[8:7];
  // The shadow bytes answer in the register page, right above the status word.
  assign nv_target = (cpu_bus.addr[15:4] == 12'h000) &&
                     (cpu_bus.addr[3:0] >= epc_pkg::OFF_NV_CONFIG) &&
                     (cpu_bus.addr[3:0] <= epc_pkg::OFF_NV_DIV_LOW);
  assign window = in_array || nv_target;
  assign erase_op = (mode != epc_pkg::EPC_BYTE_PROGRAM);

  // Protection check of a candidate capture address.
  always_comb begin
    blocked = array_config_r[blk];
    if (secure) begin
      if ((cpu_bus.addr >= epc_pkg::SECURE_LO) && (cpu_bus.addr <= epc_pkg::SECURE_HI)) begin
        blocked = 1'b1;
      end
      if ((mode == epc_pkg::EPC_BLOCK_ERASE) || (mode == epc_pkg::EPC_BULK_ERASE)) begin
        blocked = 1'b1;
      end
    end
    if ((mode == epc_pkg::EPC_BULK_ERASE) && (array_config_r[3:0] != 4'h0)) begin
      blocked = 1'b1;
    end
    // Shadow bytes ignore the block bits and follow their own locks instead.
    if (nv_target) begin
      blocked = 1'b0;
      if ((cpu_bus.addr[3:0] != epc_pkg::OFF_NV_CONFIG) && div_lock) begin
        blocked = 1'b1;
      end
      // Erasing the config shadow would lift security, so it is refused once set.
      if ((cpu_bus.addr[3:0] == epc_pkg::OFF_NV_CONFIG) && secure && erase_op) begin
        blocked = 1'b1;
      end
    end
    allowed = window && !blocked;
  end

  // Cycle length by mode.
  // All four limits sit below the specified times, so the timer always ends first.
  always_comb begin
    case (mode)
      epc_pkg::EPC_BYTE_PROGRAM: limit = epc_pkg::TICKS_PROGRAM;
      epc_pkg::EPC_BYTE_ERASE: limit = epc_pkg::TICKS_BYTE_ERASE;
      epc_pkg::EPC_BLOCK_ERASE: limit = epc_pkg::TICKS_BLOCK_ERASE;
      default: limit = epc_pkg::TICKS_BULK_ERASE;
    endcase
  end

  // ****************************************
  // Control register
  // ****************************************
  // Latch and enable interlock here; hardware may only ever clear the enable.
  always_ff @(posedge clock) begin
    if (rst) begin
      control_r <= epc_pkg::CONTROL_RESET;
    end else if (clk_en) begin
      if (wr_ctl) begin
        control_r[7] <= reg_wdata[7];
        control_r[epc_pkg::CTL_PD_BIT] <= reg_wdata[epc_pkg::CTL_PD_BIT];
        control_r[epc_pkg::CTL_RAS_HI_BIT] <= reg_wdata[epc_pkg::CTL_RAS_HI_BIT];
        control_r[epc_pkg::CTL_RAS_LO_BIT] <= reg_wdata[epc_pkg::CTL_RAS_LO_BIT];
        control_r[epc_pkg::CTL_AUTO_BIT] <= reg_wdata[epc_pkg::CTL_AUTO_BIT];
        if (reg_wdata[epc_pkg::CTL_LATCH_BIT] || !hv_en) begin
          control_r[epc_pkg::CTL_LATCH_BIT] <= reg_wdata[epc_pkg::CTL_LATCH_BIT];
        end
        if (!reg_wdata[epc_pkg::CTL_HV_BIT]) begin
          control_r[epc_pkg::CTL_HV_BIT] <= 1'b0;
        end else if (latch_en && cap_valid_r) begin
          control_r[epc_pkg::CTL_HV_BIT] <= 1'b1;
        end
      end
      // A timer end with auto set that meets a control write in one cycle still clears the enable.
      if (done_r && auto_en) begin
        control_r[epc_pkg::CTL_HV_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Capture of address and data
  // ****************************************
  // A refused write still moves the address, but it never raises the valid flag.
  always_ff @(posedge clock) begin
    if (rst) begin
      cap_addr_r <= '0;
      cap_data_r <= epc_pkg::ERASED_BYTE;
      cap_valid_r <= 1'b0;
    end else if (clk_en) begin
      if (!latch_en) begin
        cap_valid_r <= 1'b0;
      end else if (!hv_en && cpu_bus.wr && window) begin
        cap_addr_r <= cpu_bus.addr;
        cap_data_r <= cpu_bus.data;
        cap_valid_r <= allowed;
      end else if (!hv_en && cpu_bus.rd && window) begin
        cap_addr_r <= cpu_bus.addr;
      end
    end
  end

  // ****************************************
  // Shadow copies and configuration
  // ****************************************
  // The first enabled edge after reset copies the shadows into the live registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      loaded_r <= 1'b0;
      array_config_r <= epc_pkg::NV_CONFIG_FACTORY;
      div_high_r <= 8'h80;
      div_low_r <= 8'h00;
    end else if (clk_en) begin
      if (!loaded_r) begin
        loaded_r <= 1'b1;
        array_config_r <= nv_config_r;
        div_high_r <= nv_div_high_r & epc_pkg::DIV_HIGH_MASK;
        div_low_r <= nv_div_low_r;
      end else if (reg_wr) begin
        if (reg_addr == epc_pkg::OFF_ARRAY_CONFIG) begin
          array_config_r[7:5] <= reg_wdata[7:5];
        end
        if (!latch_en && !div_lock) begin
          if (reg_addr == epc_pkg::OFF_DIV_HIGH) begin
            div_high_r <= reg_wdata & epc_pkg::DIV_HIGH_MASK;
          end
          if (reg_addr == epc_pkg::OFF_DIV_LOW) begin
            div_low_r <= reg_wdata;
          end
        end
      end
    end
  end

  // Shadow bytes model the nonvolatile cells; they keep their value over reset.
  // A commit waits for the end of a job, so a cycle aborted by stop leaves them alone.
  always_ff @(posedge clock) begin
    if (clk_en && job_end_r && cap_valid_r && (cap_addr_r[15:4] == 12'h000)) begin
      case (cap_addr_r[3:0])
        epc_pkg::OFF_NV_CONFIG: nv_config_r <= erase_op ? epc_pkg::ERASED_BYTE :
                                                nv_config_r & cap_data_r;
        epc_pkg::OFF_NV_DIV_HIGH: if (!div_lock) begin
          nv_div_high_r <= erase_op ? epc_pkg::ERASED_BYTE : nv_div_high_r & cap_data_r;
        end
        epc_pkg::OFF_NV_DIV_LOW: if (!div_lock) begin
          nv_div_low_r <= erase_op ? epc_pkg::ERASED_BYTE : nv_div_low_r & cap_data_r;
        end
        default: nv_config_r <= nv_config_r;
      endcase
    end
  end

  // ****************************************
  // Timebase divider and cycle timer
  // ****************************************
  // The prescaler keeps running between jobs and pauses only in stop.
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      tick_r <= 1'b0;
      if (ref_tick && !stop_mode) begin
        if (pre_cnt_r + 11'h001 >= {div_high_r[2:0], div_low_r}) begin
          pre_cnt_r <= '0;
          tick_r <= 1'b1;
        end else begin
          pre_cnt_r <= pre_cnt_r + 11'h001;
        end
      end
    end
  end

  // Cycle state machine: runs while high voltage is on, holds during stop.
  // A timer end without auto leaves the enable set; ran_out_r blocks a second run.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= epc_pkg::EPC_IDLE;
      tick_cnt_r <= '0;
      done_r <= 1'b0;
      job_end_r <= 1'b0;
      ran_out_r <= 1'b0;
    end else if (clk_en) begin
      done_r <= 1'b0;
      job_end_r <= 1'b0;
      if (!hv_en) begin
        ran_out_r <= 1'b0;
      end
      case (state_r)
        epc_pkg::EPC_IDLE: begin
          tick_cnt_r <= '0;
          if (hv_en && latch_en && cap_valid_r && !ran_out_r) begin
            state_r <= epc_pkg::EPC_RUN;
          end
        end
        epc_pkg::EPC_RUN: begin
          if (!hv_en) begin
            // Software ended the cycle by hand; entering stop now aborts it unsaved.
            job_end_r <= !stop_mode;
            state_r <= epc_pkg::EPC_IDLE;
          end else if (stop_mode) begin
            state_r <= epc_pkg::EPC_HOLD;
          end else if (tick_r) begin
            if (tick_cnt_r + 12'h001 >= limit) begin
              done_r <= 1'b1;
              job_end_r <= 1'b1;
              ran_out_r <= 1'b1;
              state_r <= epc_pkg::EPC_IDLE;
            end else begin
              tick_cnt_r <= tick_cnt_r + 12'h001;
            end
          end
        end
        epc_pkg::EPC_HOLD: begin
          if (!stop_mode) begin
            tick_cnt_r <= '0;
            state_r <= epc_pkg::EPC_RUN;
          end
        end
        default: state_r <= epc_pkg::EPC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      array_rdata <= 8'h00;
      array_busy <= 1'b0;
      array_power_down <= 1'b0;
      charge_pump_on <= 1'b0;
      cell_op <= '0;
    end else if (clk_en) begin
      array_power_down <= control_r[epc_pkg::CTL_PD_BIT] || stop_mode;
      charge_pump_on <= (state_r == epc_pkg::EPC_RUN) && hv_en && !stop_mode;
      array_busy <= (state_r != epc_pkg::EPC_IDLE);
      cell_op.erase <= mode[0] | mode[1];
      cell_op.scope <= mode;
      cell_op.addr <= cap_addr_r;
      cell_op.data <= cap_data_r;
      array_rdata <= latch_en ? cap_data_r : cell_rdata;
      if (reg_rd) begin
        case (reg_addr)
          epc_pkg::OFF_CONTROL: reg_rdata <= control_r;
          epc_pkg::OFF_ARRAY_CONFIG: reg_rdata <= array_config_r;
          epc_pkg::OFF_DIV_HIGH: reg_rdata <= div_high_r;
          epc_pkg::OFF_DIV_LOW: reg_rdata <= div_low_r;
          // Status also shows wait, which never stalls a running cycle.
          epc_pkg::OFF_STATUS: reg_rdata <= {4'h0, wait_mode, cap_valid_r, state_r};
          epc_pkg::OFF_NV_CONFIG: reg_rdata <= nv_config_r;
          epc_pkg::OFF_NV_DIV_HIGH: reg_rdata <= nv_div_high_r;
          epc_pkg::OFF_NV_DIV_LOW: reg_rdata <= nv_div_low_r;
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

/* File: epc_pkg.sv */
// Purpose: Shared constants and types for the nonvolatile program/erase controller.
// Assumes: 8-bit register port, 25 MHz clock, 11-bit array address space.
// Notes: Register offsets are local to this block's register port.
package epc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_ARRAY_CONFIG = 4'h1;
  localparam logic [3:0] OFF_DIV_HIGH = 4'h2;
  localparam logic [3:0] OFF_DIV_LOW = 4'h3;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_NV_CONFIG = 4'h5;
  localparam logic [3:0] OFF_NV_DIV_HIGH = 4'h6;
  localparam logic [3:0] OFF_NV_DIV_LOW = 4'h7;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_HV_BIT = 0;
  localparam int CTL_AUTO_BIT = 1;
  localparam int CTL_LATCH_BIT = 2;
  localparam int CTL_RAS_LO_BIT = 3;
  localparam int CTL_RAS_HI_BIT = 4;
  localparam int CTL_PD_BIT = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DIV_HIGH_MASK = 8'h87;
  localparam int DIV_SEC_BIT = 7;

  // ****************************************
  // Array map
  // ****************************************
  localparam logic [15:0] ARRAY_BASE = 16'h0600;
  localparam logic [15:0] ARRAY_LAST = 16'h07ff;
  localparam logic [15:0] SECURE_LO = 16'h06f0;
  localparam logic [15:0] SECURE_HI = 16'h06ff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] NV_CONFIG_FACTORY = 8'hf0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_HZ = 25000000;
  localparam int TICK_US = 35;
  localparam int TICK_CYCLES_DEFAULT = (CLOCK_HZ / 1000 * TICK_US + 500) / 1000;
  localparam logic [10:0] DIV_RESET = 11'(TICK_CYCLES_DEFAULT);
  localparam logic [11:0] TICKS_PROGRAM = 12'h0fe;
  localparam logic [11:0] TICKS_BYTE_ERASE = 12'h0fe;
  localparam logic [11:0] TICKS_BLOCK_ERASE = 12'h0fe;
  localparam logic [11:0] TICKS_BULK_ERASE = 12'h0fe;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    EPC_BYTE_PROGRAM = 2'b00,
    EPC_BYTE_ERASE = 2'b01,
    EPC_BLOCK_ERASE = 2'b10,
    EPC_BULK_ERASE = 2'b11
  } epc_mode_t;

  typedef enum logic [1:0] {
    EPC_IDLE = 2'b00,
    EPC_RUN = 2'b01,
    EPC_HOLD = 2'b10
  } epc_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } epc_bus_t;

  typedef struct packed {
    logic erase;
    logic [1:0] scope;
    logic [15:0] addr;
    logic [7:0] data;
  } epc_cell_t;

endpackage

/* File: epc_cell_model.sv */
// Purpose: Behavioural array cells beside the program/erase controller.
// Assumes: One clock; a cell job ends when the charge pump turns off.
// Notes: Powered-down reads show the inverse of the last value.
`timescale 1ns/10ps
module epc_cell_model (
  // Clock.
  input wire logic clock,
  // Controller side.
  input wire epc_pkg::epc_cell_t cell_op,
  input wire logic charge_pump_on,
  input wire logic array_power_down,
  // Read data back to the controller.
  output logic [7:0] cell_rdata
);
  logic [7:0] mem [0:2047];
  logic pump_q = 1'b0;
  logic [7:0] last_q = 8'h00;

  // Commit the job when the pump drops; erase sets bits, program clears them.
  always @(posedge clock) begin
    pump_q <= charge_pump_on;
    last_q <= cell_rdata;
    if (pump_q && !charge_pump_on) begin
      if (cell_op.erase) begin
        mem[cell_op.addr[10:0]] <= epc_pkg::ERASED_BYTE;
      end else begin
        mem[cell_op.addr[10:0]] <= mem[cell_op.addr[10:0]] & cell_op.data;
      end
    end
  end

  // Unpowered cells give no stable data.
  assign cell_rdata = array_power_down ? ~last_q : mem[cell_op.addr[10:0]];
endmodule

/* File: epc_ctrl_properties.sv */
// Purpose: Port-level assertions for the program/erase controller.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound to every controller instance.
`timescale 1ns/10ps
module epc_ctrl_properties (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Array side.
  input wire logic array_busy,
  input wire logic array_power_down,
  input wire logic charge_pump_on,
  input wire epc_pkg::epc_cell_t cell_op,
  input wire logic stop_mode
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_rdata_idle_zero: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_freeze_no_enable: assert property (!clk_en |=> $stable(charge_pump_on) &&
    $stable(array_busy) && $stable(array_power_down)) else $error("state moved while frozen");
  a_stop_no_pump: assert property (clk_en && stop_mode |=> !charge_pump_on)
    else $error("pump on in stop");
  a_stop_power_down: assert property (clk_en && stop_mode |=> array_power_down)
    else $error("array powered in stop");
  a_stop_holds_busy: assert property (clk_en && stop_mode && array_busy |=> array_busy)
    else $error("cycle dropped in stop");
  a_pump_needs_cycle: assert property ($rose(charge_pump_on) |-> array_busy)
    else $error("pump on without cycle");
  a_pump_valid_addr: assert property (charge_pump_on |-> cell_op.addr inside
    {[epc_pkg::ARRAY_BASE:epc_pkg::ARRAY_LAST], [16'h0005:16'h0007]})
    else $error("pump on for invalid address");
  a_pd_bit_applies: assert property (clk_en && reg_wr && reg_addr == epc_pkg::OFF_CONTROL &&
    reg_wdata[epc_pkg::CTL_PD_BIT] |-> ##[1:2] array_power_down) else $error("power-down ignored");
endmodule

bind epc_ctrl epc_ctrl_properties chk (.clock, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .array_busy, .array_power_down, .charge_pump_on, .cell_op, .stop_mode);

/* File: epc_ctrl_bench.sv */
// Purpose: Self-checking bench for the program/erase controller.
// Assumes: Shadow bytes start at factory values and are rewritten by programming.
// Notes: Divisor 2 with a tick every other cycle keeps cycles short.
`timescale 1ns/10ps
module epc_ctrl_bench;
  // ****************************************
  // Signals
  // ****************************************
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  epc_pkg::epc_bus_t cpu_bus = '0;
  logic [7:0] array_rdata;
  logic array_busy;
  logic [7:0] cell_rdata;
  logic array_power_down;
  logic charge_pump_on;
  epc_pkg::epc_cell_t cell_op;
  logic ref_tick = 1'b0;
  logic stop_mode = 1'b0;
  logic wait_mode = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;

  epc_ctrl dut (.clock, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_bus, .array_rdata, .array_busy, .cell_rdata, .array_power_down, .charge_pump_on,
    .cell_op, .ref_tick, .stop_mode, .wait_mode);
  epc_cell_model cells (.clock, .cell_op, .charge_pump_on, .array_power_down, .cell_rdata);

  // Clock and reference tick.
  always #20 clock = ~clock;
  always @(posedge clock) ref_tick <= ~ref_tick;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask
  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    cpu_bus <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge clock);
    cpu_bus <= '0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 4000 && array_busy !== 1'b0; i++) @(posedge clock);
    @(posedge clock);
    #1 chk("busy", 8'h00, {7'h00, array_busy});
  endtask
  // Manual job: latch, capture, voltage on, hold, voltage off, latch off.
  task automatic nv_op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    wr(epc_pkg::OFF_CONTROL, c);
    cpu(1'b1, a, d);
    wr(epc_pkg::OFF_CONTROL, c | 8'h01);
    repeat (1100) @(posedge clock);
    wr(epc_pkg::OFF_CONTROL, c);
    wr(epc_pkg::OFF_CONTROL, 8'h00);
  endtask
  // Timed job with automatic termination.
  task automatic run(input logic [7:0] c, input logic [15:0] a);
    wr(epc_pkg::OFF_CONTROL, c);
    cpu(1'b1, a, 8'h5a);
    wr(epc_pkg::OFF_CONTROL, c | 8'h01);
    rd(epc_pkg::OFF_CONTROL, c | 8'h01, "control");
    wr(epc_pkg::OFF_CONTROL, (c & 8'hfb) | 8'h01);
    rd(epc_pkg::OFF_CONTROL, c | 8'h01, "control");
    wait_idle();
    rd(epc_pkg::OFF_CONTROL, c, "control");
    cpu(1'b0, a, 8'h00);
    #1 chk("array_rdata", 8'h5a, array_rdata);
    wr(epc_pkg::OFF_CONTROL, 8'h00);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  // Watchdog against a hung cycle.
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    do_reset();
    // Factory divider: 25 MHz times 35 us plus one half, rounded down, is 875.
    rd(epc_pkg::OFF_ARRAY_CONFIG, 8'hf0, "config");
    rd(epc_pkg::OFF_DIV_HIGH, 8'h83, "div_high");
    rd(epc_pkg::OFF_DIV_LOW, 8'h6b, "div_low");
    nv_op(8'h0c, 16'h0005, 8'h00);
    nv_op(8'h04, 16'h0005, 8'hf1);
    nv_op(8'h0c, 16'h0006, 8'h00);
    nv_op(8'h04, 16'h0006, 8'h80);
    nv_op(8'h0c, 16'h0007, 8'h00);
    nv_op(8'h04, 16'h0007, 8'h02);
    do_reset();
    rd(epc_pkg::OFF_ARRAY_CONFIG, 8'hf1, "config");
    rd(epc_pkg::OFF_DIV_HIGH, 8'h80, "div_high");
    rd(epc_pkg::OFF_DIV_LOW, 8'h02, "div_low");
    rd(epc_pkg::OFF_NV_CONFIG, 8'hf1, "nv_config");
    rd(epc_pkg::OFF_NV_DIV_LOW, 8'h02, "nv_div_low");
    wr(epc_pkg::OFF_ARRAY_CONFIG, 8'h0e);
    rd(epc_pkg::OFF_ARRAY_CONFIG, 8'h11, "config");
    wr(epc_pkg::OFF_CONTROL, 8'he0);
    rd(epc_pkg::OFF_CONTROL, 8'ha0, "control");
    chk("power_down", 8'h01, {7'h00, array_power_down});
    wr(epc_pkg::OFF_CONTROL, 8'h01);
    rd(epc_pkg::OFF_CONTROL, 8'h00, "control");
    wr(epc_pkg::OFF_CONTROL, 8'h04);
    cpu(1'b1, 16'h0600, 8'h11);
    wr(epc_pkg::OFF_CONTROL, 8'h05);
    rd(epc_pkg::OFF_CONTROL, 8'h04, "control");
    wr(epc_pkg::OFF_CONTROL, 8'h00);
    wr(epc_pkg::OFF_DIV_LOW, 8'h03);
    rd(epc_pkg::OFF_DIV_LOW, 8'h03, "div_low");
    wr(epc_pkg::OFF_CONTROL, 8'h04);
    wr(epc_pkg::OFF_DIV_LOW, 8'h09);
    rd(epc_pkg::OFF_DIV_LOW, 8'h03, "div_low");
    wr(epc_pkg::OFF_CONTROL, 8'h00);
    wr(epc_pkg::OFF_DIV_LOW, 8'h02);
    wait_mode <= 1'b1;
    for (int m = 0; m < 3; m++) run({3'h0, m[1:0], 3'b110}, 16'h0700 + 16'(m * 16));
    wait_mode <= 1'b0;
    wr(epc_pkg::OFF_CONTROL, 8'h04);
    cpu(1'b1, 16'h0720, 8'h00);
    wr(epc_pkg::OFF_CONTROL, 8'h05);
    wr(epc_pkg::OFF_CONTROL, 8'h00);
    rd(epc_pkg::OFF_CONTROL, 8'h04, "control");
    wr(epc_pkg::OFF_CONTROL, 8'h00);
    rd(epc_pkg::OFF_CONTROL, 8'h00, "control");
    wait_idle();
    wr(epc_pkg::OFF_CONTROL, 8'h06);
    cpu(1'b1, 16'h0740, 8'h33);
    wr(epc_pkg::OFF_CONTROL, 8'h07);
    repeat (20) @(posedge clock);
    clk_en <= 1'b0;
    repeat (4) @(posedge clock);
    clk_en <= 1'b1;
    stop_mode <= 1'b1;
    repeat (10) @(posedge clock);
    #1 chk("pump", 8'h00, {7'h00, charge_pump_on});
    chk("busy", 8'h01, {7'h00, array_busy});
    @(posedge clock);
    stop_mode <= 1'b0;
    wait_idle();
    rd(epc_pkg::OFF_CONTROL, 8'h06, "control");
    wr(epc_pkg::OFF_CONTROL, 8'h00);
    tally_and_finish();
  end
endmodule
